// ===== logic/sensor_link_map.vh
// Constants for the humidity and temperature sensor serial command port
`ifndef SENSOR_LINK_MAP_VH
`define SENSOR_LINK_MAP_VH

`define DEV_ADDR 7'h70
`define CMD_STRETCH_T_FIRST 16'h7ca2
`define CMD_STRETCH_H_FIRST 16'h5c24
`define CMD_NOSTRETCH_T_FIRST 16'h7866
`define CMD_NOSTRETCH_H_FIRST 16'h58e0
`define CMD_SOFT_RESET 16'h805d

`define CRC_POLY 8'h31
`define CRC_INIT 8'hff

`define CLK_PERIOD_NS 25
// Typical figures; each stays inside the worst-case limit
`define POWER_UP_DELAY_NS 182000
`define SOFT_RESET_DELAY_NS 173000
`define CONVERSION_DURATION_NS 10800000
`define POWER_UP_CYCLES (`POWER_UP_DELAY_NS / `CLK_PERIOD_NS)
`define SOFT_RESET_CYCLES (`SOFT_RESET_DELAY_NS / `CLK_PERIOD_NS)
`define CONVERSION_CYCLES (`CONVERSION_DURATION_NS / `CLK_PERIOD_NS)
// Setup given to the first read bit before a held clock is freed
`define DATA_SETUP_CYCLES 4'h4

`endif

// ===== logic/sensor_link.v
// Serial command port of the humidity and temperature sensor
`timescale 1ns/1ps
`include "sensor_link_map.vh"

module sensor_link #(
    parameter [31:0] POWER_UP_CYCLES = `POWER_UP_CYCLES,
    parameter [31:0] SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES,
    parameter [31:0] CONVERSION_CYCLES = `CONVERSION_CYCLES
) (
    input wire clk_sys,
    input wire srst,
    input wire scl_in,
    input wire sda_in,
    output wire scl_out,
    output wire scl_oe,
    output wire sda_out,
    output reg sda_oe,
    input wire [15:0] humidity_value,
    input wire [15:0] temperature_value,
    output reg conversion_start,
    output reg conversion_busy,
    output wire idle
);

    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RX = 6'h02;
    localparam [5:0] ST_ACK = 6'h04;
    localparam [5:0] ST_TX = 6'h08;
    localparam [5:0] ST_MACK = 6'h10;
    localparam [5:0] ST_HOLD = 6'h20;

    function [7:0] crc8;
        input [15:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = `CRC_INIT;
            for (i = 15; i >= 0; i = i - 1) begin
                if (c[7] ^ d[i])
                    c = {c[6:0], 1'b0} ^ `CRC_POLY;
                else
                    c = {c[6:0], 1'b0};
            end
            crc8 = c;
        end
    endfunction

    function [47:0] frame_of;
        input [15:0] first;
        input [15:0] second;
        begin
            frame_of = {first, crc8(first), second, crc8(second)};
        end
    endfunction

    // Three-stage pin synchronisers with agreement filter
    reg [2:0] scl_sync;
    reg [2:0] sda_sync;
    reg scl_f;
    reg sda_f;
    reg scl_p;
    reg sda_p;

    always @(posedge clk_sys) begin
        if (srst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            if (scl_sync[1] == scl_sync[2])
                scl_f <= scl_sync[2];
            if (sda_sync[1] == sda_sync[2])
                sda_f <= sda_sync[2];
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    wire scl_rise = scl_f & ~scl_p;
    wire scl_fall = ~scl_f & scl_p;
    wire bus_start = scl_f & scl_p & sda_p & ~sda_f;
    wire bus_stop = scl_f & scl_p & ~sda_p & sda_f;

    reg [5:0] st;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [1:0] kind;
    reg rw;
    reg [7:0] cmd_hi;
    reg [47:0] frame;
    reg [47:0] result;
    reg [2:0] byte_idx;
    reg mack;
    reg booting;
    reg stretch;
    reg t_first;
    reg data_ready;
    reg [19:0] wait_cnt;

    wire [15:0] cmd = {cmd_hi, shreg};
    wire addr_hit = shreg[7:1] == `DEV_ADDR;
    wire is_meas = cmd == `CMD_STRETCH_T_FIRST ||
        cmd == `CMD_STRETCH_H_FIRST || cmd == `CMD_NOSTRETCH_T_FIRST ||
        cmd == `CMD_NOSTRETCH_H_FIRST;
    wire cmd_stretch = cmd == `CMD_STRETCH_T_FIRST ||
        cmd == `CMD_STRETCH_H_FIRST;
    wire cmd_t_first = cmd == `CMD_STRETCH_T_FIRST ||
        cmd == `CMD_NOSTRETCH_T_FIRST;
    // Read headers need either a stretching conversion or stored results
    wire hdr_ok = addr_hit && !booting && (shreg[0] ?
        (conversion_busy ? stretch : data_ready) :
        !conversion_busy);

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = st[5];
    assign idle = st[0] && !booting && !conversion_busy;

    always @(posedge clk_sys) begin
        if (srst) begin
            st <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            kind <= 2'h0;
            rw <= 1'b0;
            cmd_hi <= 8'h00;
            frame <= 48'h0;
            result <= 48'h0;
            byte_idx <= 3'h0;
            mack <= 1'b0;
            sda_oe <= 1'b0;
            booting <= 1'b1;
            wait_cnt <= POWER_UP_CYCLES[19:0];
            stretch <= 1'b0;
            t_first <= 1'b0;
            data_ready <= 1'b0;
            conversion_start <= 1'b0;
            conversion_busy <= 1'b0;
        end else begin
            conversion_start <= 1'b0;
            // Shared timer: boot/soft reset and conversion never overlap
            if (wait_cnt != 20'h0)
                wait_cnt <= wait_cnt - 20'h1;
            if (booting && wait_cnt == 20'h1)
                booting <= 1'b0;
            if (conversion_busy && wait_cnt == 20'h1) begin
                conversion_busy <= 1'b0;
                data_ready <= 1'b1;
                result <= t_first ?
                    frame_of(temperature_value, humidity_value) :
                    frame_of(humidity_value, temperature_value);
            end
            if (bus_start) begin
                st <= ST_RX;
                bit_cnt <= 4'h0;
                kind <= 2'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                st <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st)
                ST_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (kind == 2'h0) begin
                            rw <= shreg[0];
                            if (hdr_ok) begin
                                sda_oe <= 1'b1;
                                st <= ST_ACK;
                            end else begin
                                st <= ST_IDLE;
                            end
                        end else begin
                            sda_oe <= 1'b1;
                            st <= ST_ACK;
                            if (kind == 2'h1)
                                cmd_hi <= shreg;
                            else if (is_meas) begin
                                conversion_start <= 1'b1;
                                conversion_busy <= 1'b1;
                                data_ready <= 1'b0;
                                stretch <= cmd_stretch;
                                t_first <= cmd_t_first;
                                wait_cnt <= CONVERSION_CYCLES[19:0];
                            end else if (cmd == `CMD_SOFT_RESET) begin
                                booting <= 1'b1;
                                data_ready <= 1'b0;
                                wait_cnt <= SOFT_RESET_CYCLES[19:0];
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        if (kind == 2'h0 && rw) begin
                            if (conversion_busy) begin
                                st <= ST_HOLD;
                            end else begin
                                frame <= result;
                                byte_idx <= 3'h0;
                                sda_oe <= ~result[47];
                                st <= ST_TX;
                            end
                        end else if (kind == 2'h2) begin
                            st <= ST_IDLE;
                        end else begin
                            kind <= kind + 2'h1;
                            st <= ST_RX;
                        end
                    end
                end
                ST_HOLD: begin
                    // SCL stays low until results are latched, then a
                    // few cycles more so the first bit settles first
                    if (!conversion_busy) begin
                        frame <= result;
                        byte_idx <= 3'h0;
                        sda_oe <= ~result[47];
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `DATA_SETUP_CYCLES) begin
                            bit_cnt <= 4'h0;
                            st <= ST_TX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        frame <= {frame[46:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'b0;
                            st <= ST_MACK;
                        end else begin
                            sda_oe <= ~frame[46];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise)
                        mack <= ~sda_f;
                    else if (scl_fall) begin
                        if (mack && byte_idx != 3'h5) begin
                            byte_idx <= byte_idx + 3'h1;
                            sda_oe <= ~frame[47];
                            st <= ST_TX;
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
                endcase
            end
        end
    end

endmodule

// ===== dv/sensor_link_chk.sv
// Port checker for the sensor serial command port
`timescale 1ns/1ps
module sensor_link_chk #(
    parameter [31:0] POWER_UP_CYCLES = 32'd20,
    parameter [31:0] CONVERSION_CYCLES = 32'd200
) (
    input wire clk_sys,
    input wire srst,
    input wire scl_in,
    input wire scl_oe,
    input wire sda_oe,
    input wire conversion_start,
    input wire conversion_busy,
    input wire idle
);
    reg [31:0] boot_cnt;
    reg [31:0] busy_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Saturates so a long run never wraps back into the boot window
    always @(posedge clk_sys) begin
        if (srst)
            boot_cnt <= 32'h0;
        else if (boot_cnt != POWER_UP_CYCLES + 9)
            boot_cnt <= boot_cnt + 1;
        if (srst || !conversion_busy)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    AST_BOOT_NACK: assert property (
        boot_cnt < POWER_UP_CYCLES |-> !sda_oe)
        else $error("ack during boot");
    AST_BOOT_IDLE: assert property (
        boot_cnt == POWER_UP_CYCLES + 8 |-> idle)
        else $error("not idle after boot");
    AST_IDLE_QUIET: assert property (
        idle |-> !conversion_busy && !scl_oe && !sda_oe)
        else $error("idle while active");
    AST_BUSY_MAX: assert property (
        conversion_busy |-> busy_cnt < CONVERSION_CYCLES)
        else $error("conversion too long");
    AST_START_FOLLOW: assert property (
        conversion_start |=> conversion_busy && !conversion_start)
        else $error("start without busy");
    AST_START_AT_ACK: assert property (
        conversion_start |-> ##[0:8] sda_oe)
        else $error("start away from ack");
    AST_STRETCH_CAUSE: assert property (
        $rose(scl_oe) |-> conversion_busy)
        else $error("stretch while not converting");
    // The clock is freed at most six cycles after the conversion ends
    AST_STRETCH_END: assert property (
        $fell(conversion_busy) |-> ##[0:6] !scl_oe)
        else $error("stretch outlives conversion");
    AST_ACK_STEADY: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("data moved while clock high");
    COV_STRETCH: cover property ($fell(scl_oe));
    COV_CONV: cover property (conversion_start);
    COV_DONE: cover property ($fell(conversion_busy));
endmodule
bind sensor_link sensor_link_chk #(
    .POWER_UP_CYCLES(POWER_UP_CYCLES),
    .CONVERSION_CYCLES(CONVERSION_CYCLES)
) i_sensor_link_chk (
    .clk_sys(clk_sys),
    .srst(srst),
    .scl_in(scl_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe),
    .conversion_start(conversion_start),
    .conversion_busy(conversion_busy),
    .idle(idle)
);

// ===== dv/bus_master_model.sv
// Behavioural bus master on the two open-drain lines
`timescale 1ns/1ps
module bus_master_model (
    output logic scl_low,
    output logic sda_low,
    input wire scl,
    input wire sda
);
    // Lines are only ever pulled low; the bench pull-ups give the high level
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic start;
        #25;
        sda_low <= 1'b0;
        #125;
        scl_low <= 1'b0;
        wait (scl === 1'b1);
        #50;
        sda_low <= 1'b1;
        #50;
        scl_low <= 1'b1;
    endtask
    task automatic stop;
        #25;
        sda_low <= 1'b1;
        #125;
        scl_low <= 1'b0;
        wait (scl === 1'b1);
        #50;
        sda_low <= 1'b0;
        #100;
    endtask
    // Line changes land on clock edges as non-blocking updates, so the
    // input flops never race them. A bit is a fixed 200 ns, scaled down
    // like the block's timers and never shortened low 150 ns
    // since the block answers 125 ns after a fall, and high 50 ns.
    // A held clock only lengthens the low phase.
    task automatic clk_bit(input logic b, output logic r);
        #25;
        sda_low <= !b;
        #125;
        scl_low <= 1'b0;
        wait (scl === 1'b1);
        #25;
        r = sda;
        #25;
        scl_low <= 1'b1;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(last, r);
    endtask
endmodule

// ===== dv/sensor_link_test.sv
// Self-checking bench for the sensor serial command port
`timescale 1ns/1ps
`include "sensor_link_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module sensor_link_test;
    localparam [31:0] PU = 32'd200;
    localparam [31:0] SR = 32'd200;
    localparam [31:0] CV = 32'd400;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [15:0] humidity_value = 16'h6666;
    logic [15:0] temperature_value = 16'hbeef;
    wire scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low;
    wire conversion_start, conversion_busy, idle;
    wire scl = ~(scl_low | (scl_oe & ~scl_out));
    wire sda = ~(sda_low | (sda_oe & ~sda_out));
    int errors = 0;
    int checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    sensor_link #(.POWER_UP_CYCLES(PU), .SOFT_RESET_CYCLES(SR),
        .CONVERSION_CYCLES(CV)) i_sensor_link (.clk_sys(clk_sys),
        .srst(srst), .scl_in(scl), .sda_in(sda), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .humidity_value(humidity_value),
        .temperature_value(temperature_value),
        .conversion_start(conversion_start),
        .conversion_busy(conversion_busy), .idle(idle));
    bus_master_model i_bus_master_model (.scl_low(scl_low),
        .sda_low(sda_low), .scl(scl), .sda(sda));
    function automatic [7:0] crc8(input [15:0] d);
        reg [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction
    task automatic bus_start;
        i_bus_master_model.start();
    endtask
    task automatic bus_stop;
        i_bus_master_model.stop();
    endtask
    task automatic send(input logic [7:0] d, input logic want);
        logic a;
        i_bus_master_model.wr_byte(d, a);
        `CHK(a, want)
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_boot;
        bus_start();
        send(8'he0, 1'b0);
        bus_stop();
        repeat (PU) @(posedge clk_sys);
        `CHK(idle, 1'b1)
        bus_start();
        send(8'he2, 1'b0);
        bus_stop();
    endtask
    task automatic t_measure(input [15:0] cmd, input logic st, input logic tf);
        logic [7:0] b;
        logic [47:0] exp;
        logic [15:0] t;
        logic [15:0] h;
        t = cmd ^ 16'h1234;
        h = ~cmd;
        exp = tf ? {t, crc8(t), h, crc8(h)} : {h, crc8(h), t, crc8(t)};
        @(posedge clk_sys);
        temperature_value <= t;
        humidity_value <= h;
        bus_start();
        send(8'he0, 1'b1);
        send(cmd[15:8], 1'b1);
        send(cmd[7:0], 1'b1);
        `CHK(conversion_busy, 1'b1)
        bus_start();
        if (!st) begin
            send(8'he1, 1'b0);
            bus_start();
            send(8'he0, 1'b0);
            bus_stop();
            repeat (CV + 20) @(posedge clk_sys);
            `CHK(conversion_busy, 1'b0)
            bus_start();
        end
        send(8'he1, 1'b1);
        repeat (8) @(posedge clk_sys);
        `CHK(scl_oe, st)
        for (int i = 0; i < 6; i++) begin
            i_bus_master_model.rd_byte(i == 5, b);
            `CHK(b, exp[47 - 8 * i -: 8])
        end
        bus_stop();
    endtask
    task automatic t_early_nack;
        logic [7:0] b;
        bus_start();
        send(8'he1, 1'b1);
        i_bus_master_model.rd_byte(1'b1, b);
        i_bus_master_model.rd_byte(1'b1, b);
        `CHK(b, 8'hff)
        bus_stop();
    endtask
    task automatic t_soft_reset;
        bus_start();
        send(8'he0, 1'b1);
        send(8'h80, 1'b1);
        send(8'h5d, 1'b1);
        bus_stop();
        bus_start();
        send(8'he0, 1'b0);
        bus_stop();
        repeat (SR + 20) @(posedge clk_sys);
        `CHK(idle, 1'b1)
        bus_start();
        send(8'he0, 1'b1);
        bus_stop();
    endtask
    // A hung handshake ends the run here instead of running forever
    initial begin
        #1000000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_boot();
        t_measure(`CMD_STRETCH_T_FIRST, 1'b1, 1'b1);
        t_measure(`CMD_STRETCH_H_FIRST, 1'b1, 1'b0);
        t_measure(`CMD_NOSTRETCH_T_FIRST, 1'b0, 1'b1);
        t_measure(`CMD_NOSTRETCH_H_FIRST, 1'b0, 1'b0);
        t_early_nack();
        t_soft_reset();
        complete_run();
    end
endmodule
